// >>> logic/ccd_pkg.sv
// Purpose: shared constants and types of the CAN cycle diagnostics block
// Assumes: 20 MHz hclk, AHB-Lite word access, register index times four is the byte address
// Notes: all timestamps are nanoseconds, built by adding the clock period each edge
package ccd_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam logic [31:0] CLK_PERIOD_NS = 32'(1_000_000_000 / CLK_HZ);

  // register indices (byte address is index * 4)
  localparam logic [7:0] IDX_ENTRY_COUNT = 8'h00;
  localparam logic [7:0] IDX_CYCLE_NOW = 8'h01;
  localparam logic [7:0] IDX_CYCLE_PEAK = 8'h03;
  localparam logic [7:0] IDX_BUS_LOAD = 8'h04;
  localparam logic [7:0] IDX_SYNC_SENT_NOW = 8'h09;
  localparam logic [7:0] IDX_SYNC_SENT_PEAK = 8'h0b;
  localparam logic [7:0] IDX_PREP_DONE_NOW = 8'h0c;
  localparam logic [7:0] IDX_PREP_DONE_PEAK = 8'h0e;
  localparam logic [7:0] IDX_OUT_COPY_NOW = 8'h0f;
  localparam logic [7:0] IDX_OUT_COPY_PEAK = 8'h11;
  localparam logic [7:0] IDX_IN_COPY_NOW = 8'h12;
  localparam logic [7:0] IDX_IN_COPY_PEAK = 8'h14;
  localparam logic [7:0] IDX_OUT_MISS = 8'h15;
  localparam logic [7:0] IDX_IN_MISS = 8'h16;
  localparam logic [7:0] IDX_SKIPPED = 8'h17;
  localparam logic [7:0] IDX_RX_ERR_TOTAL = 8'h18;
  localparam logic [7:0] IDX_TX_ERR_TOTAL = 8'h19;
  localparam logic [7:0] IDX_RESERVED = 8'h1a;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h1b;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1c;
  localparam logic [7:0] IDX_NONE = 8'hff;

  // fixed read values
  localparam logic [7:0] ENTRY_COUNT_VAL = 8'h19;

  // interrupt status layout
  localparam int ST_W = 4;
  localparam int ST_SKIP = 0;
  localparam int ST_OUT_MISS = 1;
  localparam int ST_IN_MISS = 2;
  localparam int ST_LOAD = 3;

  // reset values
  localparam logic [31:0] RST_TIME = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [ST_W-1:0] RST_MASK = 4'h0;

  // bus load arithmetic
  localparam logic [39:0] LOAD_SCALE = 40'h00_0000_0064;
  localparam logic [2:0] DIV_TOP_BIT = 3'h6;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b01,
    LD_DIV = 2'b10
  } ccd_load_e;

  typedef struct packed {
    logic started;
    logic active;
    logic [31:0] cyc_ns;
    logic [31:0] cycle_now;
    logic [31:0] cycle_peak;
    logic [31:0] t1_now;
    logic [31:0] t1_peak;
    logic [31:0] t2_now;
    logic [31:0] t2_peak;
    logic [31:0] t3_now;
    logic [31:0] t3_peak;
    logic in_run;
    logic [31:0] in_ns;
    logic [31:0] t5_now;
    logic [31:0] t5_peak;
    logic [15:0] out_miss;
    logic [15:0] in_miss;
    logic [15:0] skip_cnt;
    logic [15:0] rx_tot;
    logic [15:0] tx_tot;
    logic [7:0] rx_prev;
    logic [7:0] tx_prev;
    logic [31:0] busy_clk;
    logic [31:0] win_clk;
    logic [7:0] win_cyc;
    ccd_load_e ld;
    logic [39:0] div_num;
    logic [31:0] div_den;
    logic [2:0] div_bit;
    logic [7:0] div_q;
    logic [15:0] load;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
  } ccd_state_s;

endpackage : ccd_pkg

// >>> logic/ccd_diag_top.sv
// Purpose: per-cycle timing, failure counters, error totals and bus load of a CAN master
// Assumes: all event inputs are one-cycle pulses from logic on hclk, error counts too
// Notes: registers are read-only except the interrupt mask; status clears on read
`timescale 1ns/1ps

// Function
// - latest CAN cycle duration in ns
// - largest cycle duration kept, 32 bits
// - sync PDO sent stamp, now and peak
// - PDO preparation done stamp, now and peak
// - output copy done stamp, now and peak
// - input copy time after shift point
// - count cycles with outputs not taken
// - count cycles with inputs not gathered
// - skip and count late cycle starts
// - accumulate receive error counter increases
// - accumulate transmit error counter increases
// - totals sourced from 8-bit controller counters
module ccd_diag_top import ccd_pkg::*; #(
  parameter int LOAD_WINDOW_CYCLES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic cycle_start,
  input wire logic output_copy_done_stamp,
  input wire logic pdo_prep_done_stamp,
  input wire logic sync_pdo_sent_stamp,
  input wire logic input_shift,
  input wire logic input_copy_done_stamp,
  input wire logic output_miss,
  input wire logic input_miss,
  input wire logic can_bus_busy,
  input wire logic [7:0] rx_err_cnt,
  input wire logic [7:0] tx_err_cnt,
  output logic cycle_active,
  output logic irq
);

  // window must fit the 8-bit cycle counter
  if (LOAD_WINDOW_CYCLES < 1 || LOAD_WINDOW_CYCLES > 255) begin : g_bad_window
    $error("LOAD_WINDOW_CYCLES must be 1 to 255");
  end

  localparam logic [7:0] WIN_LAST = 8'(LOAD_WINDOW_CYCLES);

  ccd_state_s s_ff;
  ccd_state_s nxt_s;

  // saturating adds keep the timebases and event counters pinned at full scale; the bus load window counters wrap
  function automatic logic [31:0] sat32_add(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    sat32_add = sum[32] ? 32'hffff_ffff : sum[31:0];
  endfunction : sat32_add

  function automatic logic [15:0] sat16_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    sat16_add = sum[16] ? 16'hffff : sum[15:0];
  endfunction : sat16_add

  // peak tracking shared by all five timestamps
  function automatic logic [31:0] peak_of(input logic [31:0] pk, input logic [31:0] v);
    peak_of = (v > pk) ? v : pk;
  endfunction : peak_of

  // read decode; unmapped and reserved indices read zero
  function automatic logic [31:0] rd_mux(input logic [7:0] idx, input ccd_state_s st);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      IDX_ENTRY_COUNT: v = {24'h00_0000, ENTRY_COUNT_VAL};
      IDX_CYCLE_NOW: v = st.cycle_now;
      IDX_CYCLE_PEAK: v = st.cycle_peak;
      IDX_BUS_LOAD: v = {16'h0000, st.load};
      IDX_SYNC_SENT_NOW: v = st.t3_now;
      IDX_SYNC_SENT_PEAK: v = st.t3_peak;
      IDX_PREP_DONE_NOW: v = st.t2_now;
      IDX_PREP_DONE_PEAK: v = st.t2_peak;
      IDX_OUT_COPY_NOW: v = st.t1_now;
      IDX_OUT_COPY_PEAK: v = st.t1_peak;
      IDX_IN_COPY_NOW: v = st.t5_now;
      IDX_IN_COPY_PEAK: v = st.t5_peak;
      IDX_OUT_MISS: v = {16'h0000, st.out_miss};
      IDX_IN_MISS: v = {16'h0000, st.in_miss};
      IDX_SKIPPED: v = {16'h0000, st.skip_cnt};
      IDX_RX_ERR_TOTAL: v = {16'h0000, st.rx_tot};
      IDX_TX_ERR_TOTAL: v = {16'h0000, st.tx_tot};
      IDX_IRQ_STATUS: v = {28'h000_0000, st.status};
      IDX_IRQ_MASK: v = {28'h000_0000, st.mask};
      default: v = 32'h0000_0000;
    endcase
    rd_mux = v;
  endfunction : rd_mux

  // decoded events of this edge
  logic start_ok;
  logic start_late;
  logic ahb_ap;
  logic [7:0] ap_idx;
  logic [ST_W-1:0] st_set;
  logic load_done;
  logic [39:0] trial;
  logic [7:0] q_nxt;

  assign start_ok = cycle_start && !s_ff.active;
  assign start_late = cycle_start && s_ff.active;
  assign ahb_ap = hsel && htrans[1] && hready;
  assign ap_idx = (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : IDX_NONE;
  assign trial = {8'h00, s_ff.div_den} << s_ff.div_bit;

  // whole next state in one pass
  always_comb begin
    nxt_s = s_ff;
    load_done = 1'b0;
    q_nxt = s_ff.div_q;

    // cycle timebase; a start while the last cycle still runs is dropped
    nxt_s.cyc_ns = sat32_add(s_ff.cyc_ns, CLK_PERIOD_NS);
    if (start_ok) begin
      nxt_s.started = 1'b1;
      nxt_s.active = 1'b1;
      nxt_s.cyc_ns = CLK_PERIOD_NS;
      if (s_ff.started) begin
        nxt_s.cycle_now = s_ff.cyc_ns;
        nxt_s.cycle_peak = peak_of(s_ff.cycle_peak, s_ff.cyc_ns);
      end
    end
    if (start_late) begin
      nxt_s.skip_cnt = sat16_add(s_ff.skip_cnt, 16'h0001);
    end

    // phase stamps only inside a running cycle
    if (s_ff.active && output_copy_done_stamp) begin
      nxt_s.t1_now = s_ff.cyc_ns;
      nxt_s.t1_peak = peak_of(s_ff.t1_peak, s_ff.cyc_ns);
    end
    if (s_ff.active && pdo_prep_done_stamp) begin
      nxt_s.t2_now = s_ff.cyc_ns;
      nxt_s.t2_peak = peak_of(s_ff.t2_peak, s_ff.cyc_ns);
    end
    if (s_ff.active && sync_pdo_sent_stamp) begin
      nxt_s.t3_now = s_ff.cyc_ns;
      nxt_s.t3_peak = peak_of(s_ff.t3_peak, s_ff.cyc_ns);
      nxt_s.active = start_ok; // cycle ends here, late starts counted
    end

    // input copy time runs from the shift point
    nxt_s.in_ns = sat32_add(s_ff.in_ns, CLK_PERIOD_NS);
    if (s_ff.in_run && input_copy_done_stamp) begin
      nxt_s.t5_now = s_ff.in_ns;
      nxt_s.t5_peak = peak_of(s_ff.t5_peak, s_ff.in_ns);
      nxt_s.in_run = 1'b0;
    end
    if (input_shift) begin
      nxt_s.in_run = 1'b1;
      nxt_s.in_ns = CLK_PERIOD_NS;
    end

    // failure counters
    if (output_miss) begin
      nxt_s.out_miss = sat16_add(s_ff.out_miss, 16'h0001);
    end
    if (input_miss) begin
      nxt_s.in_miss = sat16_add(s_ff.in_miss, 16'h0001);
    end

    // only rises of the controller counters are errors; falls are recovery
    nxt_s.rx_prev = rx_err_cnt;
    nxt_s.tx_prev = tx_err_cnt;
    if (rx_err_cnt > s_ff.rx_prev) begin
      nxt_s.rx_tot = sat16_add(s_ff.rx_tot, {8'h00, rx_err_cnt - s_ff.rx_prev});
    end
    if (tx_err_cnt > s_ff.tx_prev) begin
      nxt_s.tx_tot = sat16_add(s_ff.tx_tot, {8'h00, tx_err_cnt - s_ff.tx_prev});
    end

    // bus occupancy over a window of whole cycles
    nxt_s.win_clk = s_ff.win_clk + 32'h0000_0001;
    nxt_s.busy_clk = s_ff.busy_clk + {31'h0000_0000, can_bus_busy};
    if (start_ok && s_ff.started) begin
      nxt_s.win_cyc = s_ff.win_cyc + 8'h01;
      if (s_ff.win_cyc + 8'h01 >= WIN_LAST) begin
        // a window closing while dividing is dropped, not queued
        if (s_ff.ld == LD_IDLE) begin
          nxt_s.ld = LD_DIV;
          nxt_s.div_num = 40'(s_ff.busy_clk) * LOAD_SCALE;
          nxt_s.div_den = s_ff.win_clk;
          nxt_s.div_bit = DIV_TOP_BIT;
          nxt_s.div_q = 8'h00;
        end
        nxt_s.win_cyc = 8'h00;
        nxt_s.win_clk = 32'h0000_0001;
        nxt_s.busy_clk = {31'h0000_0000, can_bus_busy};
      end
    end else if (start_ok) begin
      // first start only opens the window
      nxt_s.win_clk = 32'h0000_0001;
      nxt_s.busy_clk = {31'h0000_0000, can_bus_busy};
    end

    // serial restoring divide, one quotient bit per clock
    unique case (s_ff.ld)
      LD_IDLE: begin
      end
      LD_DIV: begin
        if (s_ff.div_num >= trial) begin
          nxt_s.div_num = s_ff.div_num - trial;
          q_nxt[s_ff.div_bit] = 1'b1;
        end
        nxt_s.div_q = q_nxt;
        nxt_s.div_bit = s_ff.div_bit - 3'h1;
        if (s_ff.div_bit == 3'h0) begin
          nxt_s.ld = LD_IDLE;
          nxt_s.load = {8'h00, q_nxt};
          load_done = 1'b1;
        end
      end
      default: nxt_s.ld = LD_IDLE;
    endcase

    // interrupt status: a read clears, a same-cycle event survives
    st_set = '0;
    st_set[ST_SKIP] = start_late;
    st_set[ST_OUT_MISS] = output_miss;
    st_set[ST_IN_MISS] = input_miss;
    st_set[ST_LOAD] = load_done;
    nxt_s.status = s_ff.status | st_set;

    // bus slave: read data latched in the address phase, write in the data phase
    nxt_s.wr_pend = 1'b0;
    if (ahb_ap && !hwrite) begin
      nxt_s.rdata = rd_mux(ap_idx, s_ff);
      if (ap_idx == IDX_IRQ_STATUS) begin
        nxt_s.status = st_set;
      end
    end
    if (ahb_ap && hwrite) begin
      nxt_s.wr_pend = 1'b1;
      nxt_s.wr_idx = ap_idx;
    end
    if (s_ff.wr_pend && s_ff.wr_idx == IDX_IRQ_MASK) begin
      nxt_s.mask = hwdata[ST_W-1:0];
    end
  end

  // single state register; all figures clear on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
      s_ff.ld <= LD_IDLE;
      s_ff.mask <= RST_MASK;
      s_ff.cycle_peak <= RST_TIME;
      s_ff.out_miss <= RST_COUNT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_ff.rdata;
  assign cycle_active = s_ff.active;
  assign irq = |(s_ff.status & s_ff.mask);

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_cycle_now;
    start_ok && s_ff.started |=> s_ff.cycle_now == $past(s_ff.cyc_ns);
  endproperty
  a_cycle_now: assert property (p_cycle_now) else $error("cycle time not latched");

  property p_cycle_peak;
    s_ff.started |-> s_ff.cycle_peak >= s_ff.cycle_now;
  endproperty
  a_cycle_peak: assert property (p_cycle_peak) else $error("cycle peak below now");

  property p_t3;
    s_ff.active && sync_pdo_sent_stamp |=> s_ff.t3_now == $past(s_ff.cyc_ns)
      && s_ff.t3_peak >= s_ff.t3_now;
  endproperty
  a_t3: assert property (p_t3) else $error("sync sent stamp wrong");

  property p_t2;
    s_ff.active && pdo_prep_done_stamp |=> s_ff.t2_now == $past(s_ff.cyc_ns);
  endproperty
  a_t2: assert property (p_t2) else $error("prep done stamp wrong");

  property p_t1;
    s_ff.active && output_copy_done_stamp |=> s_ff.t1_peak >= $past(s_ff.cyc_ns);
  endproperty
  a_t1: assert property (p_t1) else $error("output copy peak missed");

  property p_t5;
    s_ff.in_run && input_copy_done_stamp && !input_shift |=>
      s_ff.t5_now == $past(s_ff.in_ns) && !s_ff.in_run;
  endproperty
  a_t5: assert property (p_t5) else $error("input copy time wrong");

  property p_out_miss;
    output_miss && s_ff.out_miss != 16'hffff |=> s_ff.out_miss == $past(s_ff.out_miss) + 16'h1;
  endproperty
  a_out_miss: assert property (p_out_miss) else $error("output miss not counted");

  property p_in_miss;
    !input_miss ##1 input_miss |=> $changed(s_ff.in_miss) || s_ff.in_miss == 16'hffff;
  endproperty
  a_in_miss: assert property (p_in_miss) else $error("input miss not counted");

  property p_skip;
    start_late && s_ff.skip_cnt != 16'hffff |=> s_ff.skip_cnt == $past(s_ff.skip_cnt) + 16'h1
      && s_ff.active == !$past(sync_pdo_sent_stamp) && s_ff.status[ST_SKIP];
  endproperty
  a_skip: assert property (p_skip) else $error("late start not skipped");

  property p_rx_tot;
    rx_err_cnt > s_ff.rx_prev && s_ff.rx_tot < 16'hff00 |=>
      s_ff.rx_tot == 16'($past(s_ff.rx_tot) + {8'h00, $past(rx_err_cnt) - $past(s_ff.rx_prev)});
  endproperty
  a_rx_tot: assert property (p_rx_tot) else $error("rx total wrong");

  property p_tx_tot;
    tx_err_cnt <= s_ff.tx_prev |=> s_ff.tx_tot == $past(s_ff.tx_tot);
  endproperty
  a_tx_tot: assert property (p_tx_tot) else $error("tx total moved");

  property p_load;
    s_ff.ld == LD_DIV |-> ##[1:7] s_ff.ld == LD_IDLE && s_ff.load <= 16'h0064;
  endproperty
  a_load: assert property (p_load) else $error("bus load divide wrong");

  property p_sat;
    s_ff.skip_cnt == 16'hffff |=> s_ff.skip_cnt == 16'hffff;
  endproperty
  a_sat: assert property (p_sat) else $error("skip counter wrapped");

  // a dropped start must leave the running cycle figure alone
  property p_late_hold;
    start_late |=> s_ff.cycle_now == $past(s_ff.cycle_now);
  endproperty
  a_late_hold: assert property (p_late_hold) else $error("late start restarted cycle");

  property p_load_flag;
    load_done |=> s_ff.status[ST_LOAD] && s_ff.load <= 16'h0064;
  endproperty
  a_load_flag: assert property (p_load_flag) else $error("load result not flagged");

  // status read leaves in status only what arrived in the same cycle
  property p_st_clear;
    ahb_ap && !hwrite && ap_idx == IDX_IRQ_STATUS |=> s_ff.status == $past(st_set);
  endproperty
  a_st_clear: assert property (p_st_clear) else $error("status not cleared by read");

  property p_mask_wr;
    s_ff.wr_pend && s_ff.wr_idx == IDX_IRQ_MASK |=> s_ff.mask == $past(hwdata[ST_W-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  c_skip: cover property (start_late);
  c_load: cover property (s_ff.ld == LD_DIV ##[1:7] s_ff.ld == LD_IDLE);
  c_irq: cover property (irq ##1 !irq);
  c_full: cover property (start_ok ##[1:100] sync_pdo_sent_stamp);
  c_t5: cover property (input_shift ##[1:20] input_copy_done_stamp);

endmodule : ccd_diag_top

// >>> bench/ccd_host_model.sv
// Purpose: host-side bus master that reads and writes the diagnostic registers
// Assumes: single whole-word transfers, one slave whose hreadyout is hready
// Notes: every wait on hready is bounded; timed_out tells the bench a wait ran out
`timescale 1ns/1ps
module ccd_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  logic timed_out = 1'b0;

  // idle bus from time zero, word size always
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // wait for hready with a bound so a dead slave cannot hang the run
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100) timed_out = 1'b1;
  endtask : wait_ready

  // one transfer: address phase held until taken, then data phase
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer
endmodule : ccd_host_model

// >>> bench/ccd_diag_top_tb.sv
// Purpose: self-checking bench of the CAN cycle diagnostics block
// Assumes: event inputs are one-cycle pulses on hclk, load window of one cycle
// Notes: bus busy held high so the expected load is exact whatever the count alignment
`timescale 1ns/1ps
module ccd_diag_top_tb;
  import ccd_pkg::*;
  logic hclk, hresetn, hready, hsel, hwrite, hresp, cycle_active, irq, busy;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ev, rx, tx;
  int n_mismatch = 0;
  int checks = 0;

  ccd_host_model host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  ccd_diag_top #(.LOAD_WINDOW_CYCLES(1)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .cycle_start(ev[0]), .output_copy_done_stamp(ev[1]), .pdo_prep_done_stamp(ev[2]),
    .sync_pdo_sent_stamp(ev[3]), .input_shift(ev[4]), .input_copy_done_stamp(ev[5]),
    .output_miss(ev[6]), .input_miss(ev[7]), .can_bus_busy(busy), .rx_err_cnt(rx),
    .tx_err_cnt(tx), .cycle_active(cycle_active), .irq(irq));

  // 50 ns clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] mx(input logic [31:0] a, input logic [31:0] b);
    return (a > b) ? a : b;
  endfunction : mx

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task final_report;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // register access by index; a hung bus ends the run at once
  task acc(input logic [7:0] idx, input logic w, input logic [31:0] wd,
           output logic [31:0] rd);
    host.xfer({22'h0, idx, 2'b00}, w, wd, rd);
    if (host.timed_out) begin
      n_mismatch++;
      final_report();
    end
  endtask : acc

  task rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    acc(idx, 1'b0, 32'h0, d);
    chk(d, exp, what);
  endtask : rdchk

  // one CAN cycle; an event driven at step i is taken i edges after the start
  task run_cycle(input int len, input int t1, input int t2, input int t3, input int t5);
    bit on;
    on = (t1 != 99);
    for (int i = 0; i < len; i++) begin
      @(posedge hclk);
      ev <= {on && i == 2, on && i == 2, i == t5 + 1, on && i == 1,
             i == t3, i == t2, i == t1, i == 0};
    end
  endtask : run_cycle

  initial begin
    logic [31:0] d, lc, pc, l1, p1, l2, p2, l3, p3, l5, p5, erx, etx;
    logic [7:0] prx, ptx, v;
    int len, t1, t2, t3, t5;
    seed = 32'd52973;
    hresetn = 1'b0;
    ev = 8'h00;
    busy = 1'b1;
    rx = 8'h00;
    tx = 8'h00;
    {pc, p1, p2, p3, p5, erx, etx} = '0;
    prx = 8'h00;
    ptx = 8'h00;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values of every index, gaps and reserved slot included
    for (int k = 0; k < 30; k++) begin
      rdchk(8'(k), (k == 0) ? 32'(ENTRY_COUNT_VAL) : 32'h0, "reset value");
    end
    host.xfer(32'h0000_0400, 1'b0, 32'h0, d);
    chk(d, 32'h0, "unmapped read");
    chk(hresp, 1'b0, "hresp");
    // three random cycles then a closing start
    for (int c = 0; c < 3; c++) begin
      len = 20 + int'(rnd() % 30);
      t1 = 1 + int'(rnd() % 5);
      t2 = t1 + 1 + int'(rnd() % 5);
      t3 = t2 + 1 + int'(rnd() % 5);
      t5 = 1 + int'(rnd() % 10);
      run_cycle(len, t1, t2, t3, t5);
      lc = 32'(len) * 50;
      l1 = 32'(t1) * 50;
      l2 = 32'(t2) * 50;
      l3 = 32'(t3) * 50;
      l5 = 32'(t5) * 50;
      pc = mx(pc, lc);
      p1 = mx(p1, l1);
      p2 = mx(p2, l2);
      p3 = mx(p3, l3);
      p5 = mx(p5, l5);
    end
    run_cycle(4, 99, 99, 99, 99);
    repeat (10) @(posedge hclk);
    rdchk(IDX_CYCLE_NOW, lc, "cycle_time_now");
    rdchk(IDX_CYCLE_PEAK, pc, "cycle_time_peak");
    rdchk(IDX_SYNC_SENT_NOW, l3, "sync_pdo_sent_time");
    rdchk(IDX_SYNC_SENT_PEAK, p3, "sync_pdo_sent_peak");
    rdchk(IDX_PREP_DONE_NOW, l2, "pdo_prep_done_time");
    rdchk(IDX_PREP_DONE_PEAK, p2, "pdo_prep_done_peak");
    rdchk(IDX_OUT_COPY_NOW, l1, "output_copy_time");
    rdchk(IDX_OUT_COPY_PEAK, p1, "output_copy_peak");
    rdchk(IDX_IN_COPY_NOW, l5, "input_copy_time");
    rdchk(IDX_IN_COPY_PEAK, p5, "input_copy_peak");
    rdchk(IDX_OUT_MISS, 32'h3, "output_miss_count");
    rdchk(IDX_IN_MISS, 32'h3, "input_miss_count");
    rdchk(IDX_BUS_LOAD, 32'd100, "bus_load_percent");
    chk(cycle_active, 1'b1, "cycle_active");
    // a start while the cycle is still open is skipped, not restarted
    run_cycle(4, 99, 99, 99, 99);
    repeat (2) @(posedge hclk);
    rdchk(IDX_SKIPPED, 32'h1, "skipped_cycle_count");
    rdchk(IDX_CYCLE_NOW, lc, "cycle_time_now after skip");
    // interrupt: masked, unmasked, cleared by reading status
    chk(irq, 1'b0, "irq masked");
    acc(IDX_IRQ_MASK, 1'b1, 32'h0000_0001, d);
    rdchk(IDX_IRQ_MASK, 32'h1, "irq mask");
    chk(irq, 1'b1, "irq raised");
    rdchk(IDX_IRQ_STATUS, 32'hf, "irq status");
    rdchk(IDX_IRQ_STATUS, 32'h0, "irq status cleared");
    chk(irq, 1'b0, "irq cleared");
    // writes to read-only places are ignored
    acc(IDX_CYCLE_NOW, 1'b1, 32'hdead_beef, d);
    rdchk(IDX_CYCLE_NOW, lc, "read-only write");
    // controller error counters: rises add up, falls are ignored
    for (int k = 0; k < 8; k++) begin
      v = 8'(rnd());
      @(posedge hclk);
      rx <= v;
      tx <= ~v;
      @(posedge hclk);
      erx = erx + ((v > prx) ? 32'(v - prx) : 32'h0);
      etx = etx + ((~v > ptx) ? 32'(8'(~v) - ptx) : 32'h0);
      prx = v;
      ptx = ~v;
    end
    repeat (2) @(posedge hclk);
    rdchk(IDX_RX_ERR_TOTAL, erx, "rx_error_total");
    rdchk(IDX_TX_ERR_TOTAL, etx, "tx_error_total");
    // second reset mid-run; counters idle first so no rise is seen on release
    @(posedge hclk);
    rx <= 8'h00;
    tx <= 8'h00;
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    chk(cycle_active, 1'b0, "cycle_active after reset");
    chk(irq, 1'b0, "irq after reset");
    rdchk(IDX_CYCLE_PEAK, 32'h0, "cycle_time_peak after reset");
    rdchk(IDX_SYNC_SENT_PEAK, 32'h0, "sync_pdo_sent_peak after reset");
    rdchk(IDX_SKIPPED, 32'h0, "skipped_cycle_count after reset");
    rdchk(IDX_RX_ERR_TOTAL, 32'h0, "rx_error_total after reset");
    final_report();
  end
endmodule : ccd_diag_top_tb
